// File: bench/mac_operating_mode_control_bench.sv
// Self-checking bench of the operating mode block
`timescale 1ns/100ps
module mac_operating_mode_control_bench;
  import omc_pkg::*;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_setup_load = 1'b0, i_tx_en = 1'b0;
  logic        i_setup_hp = 1'b0, i_setup_ho = 1'b0, i_setup_inv = 1'b0;
  logic        i_da_mcast = 1'b0, i_da_perfect = 1'b0, i_da_hash = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic        i_desc_done, i_desc_owned, i_rx_clk, i_rx_dv;
  logic [31:0] o_prdata, o_desc_addr, mode_m, cur_m, rd, v;
  logic [10:0] o_tx_threshold;
  omc_filt_type o_filt_mode, f;
  logic o_pready, o_pslverr, o_desc_req, o_addr_match, o_frame_accept;
  logic o_mcast_hash, o_phys_hash, o_mii_txen, o_sym_txen, o_loop_internal;
  logic o_loop_external, o_port_serial, o_rate_100, o_pcs_en, o_scr_en;
  logic o_store_fwd, o_rx_running, o_rx_suspended, er, m, s, fast, pc;
  logic [10:0] t10 [4] = '{11'h048, 11'h060, 11'h080, 11'h0A0};
  logic [31:0] pt [5] = '{32'h0, 32'h0044_0000, 32'h0004_0000,
                          32'h0084_0000, 32'h0184_0000};
  int n_mismatch = 0;
  int checks = 0;
  omc_mode_ctl dut (.*);
  omc_far_model far (
    .i_clk        (i_clk),
    .i_desc_req   (o_desc_req),
    .o_desc_done  (i_desc_done),
    .o_desc_owned (i_desc_owned),
    .o_rx_clk     (i_rx_clk),
    .o_rx_dv      (i_rx_dv)
  );
  always #12.5 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (w && a == 12'h000) mode_m = (d & ~32'h15) | (mode_m & 32'h15);
  endtask : apb
  task setup(input logic [2:0] b);
    @(posedge i_clk);
    i_setup_load <= 1'b1;
    {i_setup_inv, i_setup_ho, i_setup_hp} <= b;
    @(posedge i_clk);
    i_setup_load <= 1'b0;
    {mode_m[4], mode_m[2], mode_m[0]} = b;
  endtask : setup
  task wreq(input logic [31:0] a);
    int n;
    n = 0;
    while (o_desc_req !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    chk(o_desc_req, 1'b1);
    chk(o_desc_addr, a);
  endtask : wreq
  task st(input logic [1:0] e);
    repeat (8) @(negedge i_clk);
    chk({o_rx_running, o_rx_suspended}, e);
  endtask : st
  task tally_and_finish;
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  function automatic omc_filt_type fexp(input logic [4:0] b);
    casez (b)
      5'b00000: return FILT_PERF16;
      5'b00001: return FILT_HASH1;
      5'b00011: return FILT_HASHALL;
      5'b00100: return FILT_INVERSE;
      5'b?100?, 5'b01011: return FILT_PROMISC;
      5'b1000?, 5'b10011: return FILT_ALLMC;
      default: return FILT_RSVD;
    endcase
  endfunction : fexp
  function automatic logic mexp(input omc_filt_type t, input logic ho);
    case (t)
      FILT_PROMISC: return 1'b1;
      FILT_HASHALL: return i_da_hash;
      FILT_INVERSE: return !i_da_perfect;
      FILT_ALLMC: return i_da_mcast | (ho ? i_da_hash : i_da_perfect);
      FILT_HASH1: return i_da_mcast ? i_da_hash : i_da_perfect;
      default: return i_da_perfect;
    endcase
  endfunction : mexp
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(77));
    mode_m = 32'h3200_0040;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(negedge i_clk);
    chk({o_filt_mode, o_port_serial, o_tx_threshold}, 15'h4848);
    apb(0, 12'h000, 0);
    chk(rd, 32'h3200_0040);
    apb(0, 12'h020, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 32; i++) begin
      setup(i[2:0]);
      v = {1'b0, 1'($urandom), 22'h0, i[4], i[3], 6'h0};
      apb(1, 12'h000, v | ($urandom & 32'h15));
      {i_da_mcast, i_da_perfect, i_da_hash} <= 3'($urandom);
      @(posedge i_clk);
      @(negedge i_clk);
      f = fexp({mode_m[7:6], mode_m[4], mode_m[2], mode_m[0]});
      chk(o_filt_mode, f);
      chk({o_mcast_hash, o_phys_hash},
          {mode_m[0], mode_m[0] & mode_m[2]});
      m = mexp(f, mode_m[2]);
      chk({o_addr_match, o_frame_accept}, {m, m | mode_m[30]});
      apb(0, 12'h000, 0);
      chk(rd, mode_m);
    end
    for (int k = 0; k < 24; k++) begin
      v = ($urandom & 32'h4020_CC00) | pt[$urandom % 5];
      apb(1, 12'h000, v);
      i_tx_en <= 1'($urandom);
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      s = !v[18];
      fast = v[18] & !v[22];
      pc = fast & v[23];
      chk({o_tx_threshold, o_store_fwd, o_port_serial, o_rate_100, o_pcs_en,
           o_scr_en, o_loop_internal, o_loop_external},
          {fast ? 11'h080 << v[15:14] : t10[v[15:14]], v[21], s, fast, pc,
           pc & v[24], v[11:10] == 2'b01, v[11:10] == 2'b10});
      if (!s && !pc) chk(o_mii_txen, i_tx_en && v[11:10] != 2'b01);
      chk(o_sym_txen, i_tx_en && pc);
    end
    i_tx_en <= 1'b0;
    apb(1, 12'h000, 0);
    cur_m = 32'h0000_1000;
    apb(1, 12'h008, cur_m);
    far.dly = $urandom % 4;
    apb(1, 12'h000, 32'h0000_0002);
    wreq(cur_m);
    st(2'b10);
    cur_m += 32'h10;
    fork
      far.frame(4);
      wreq(cur_m);
    join
    far.own = 1'b0;
    cur_m += 32'h10;
    fork
      far.frame(3);
      wreq(cur_m);
    join
    st(2'b01);
    apb(0, 12'h004, 0);
    chk(rd[7], 1'b1);
    apb(1, 12'h000, 32'h0000_0002);
    st(2'b01);
    apb(1, 12'h000, 0);
    st(2'b00);
    apb(0, 12'h00C, 0);
    chk(rd, cur_m);
    far.own = 1'b1;
    far.dly = $urandom % 4;
    apb(1, 12'h000, 32'h0000_0002);
    wreq(cur_m);
    fork
      far.frame(8);
      begin
        repeat (20) @(posedge i_clk);
        apb(1, 12'h000, 0);
        @(negedge i_clk);
        chk(o_rx_running, 1'b1);
      end
    join
    cur_m += 32'h10;
    st(2'b00);
    apb(0, 12'h00C, 0);
    chk(rd, cur_m);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 32'h3200_0040);
    tally_and_finish;
  end
endmodule : mac_operating_mode_control_bench

// File: bench/omc_asserts.sv
// Checker of the operating mode block ports
`timescale 1ns/100ps
module omc_asserts (
  // Clock, reset, bus
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        i_setup_load,
  // Receive process
  input wire logic        i_desc_done,
  input wire logic        i_desc_owned,
  input wire logic        o_desc_req,
  input wire logic        o_rx_running,
  input wire logic        o_rx_suspended,
  // Filter, port, transmit
  input wire logic        i_tx_en,
  input wire logic        o_mii_txen,
  input wire logic        o_sym_txen,
  input wire logic        o_loop_internal,
  input wire logic        o_port_serial,
  input wire logic        o_rate_100,
  input wire logic        o_pcs_en,
  input wire logic [10:0] o_tx_threshold,
  input wire logic        o_addr_match,
  input wire logic        o_frame_accept,
  input wire logic        o_mcast_hash,
  input wire logic        o_phys_hash,
  input wire omc_pkg::omc_filt_type o_filt_mode
);
  import omc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic wr_mode;
  assign wr_mode = i_psel && i_penable && i_pwrite && i_paddr == 12'h000;
  ////////////////////////////////////////////////////////////////////////////
  a_start_fetch: assert property (wr_mode && i_pwdata[1] && !o_rx_running
    && !o_rx_suspended |-> ##2 o_desc_req && o_rx_running)
    else $error("no fetch");
  a_req_pulse: assert property (o_desc_req |=> !o_desc_req)
    else $error("request too long");
  a_no_owned: assert property (i_desc_done && !i_desc_owned && o_rx_running
    |=> o_rx_suspended) else $error("no suspend");
  a_start_held: assert property (o_rx_suspended && wr_mode && i_pwdata[1]
    |=> o_rx_suspended && !o_desc_req) else $error("start honoured");
  a_susp_stop: assert property (o_rx_suspended && wr_mode && !i_pwdata[1]
    |-> ##[1:2] !o_rx_suspended && !o_rx_running) else $error("no stop");
  a_reset_promisc: assert property ($rose(i_rstn)
    |-> o_filt_mode == FILT_PROMISC && o_port_serial) else $error("reset mode");
  a_thr_slow: assert property (!o_rate_100 |-> o_tx_threshold inside
    {11'h048, 11'h060, 11'h080, 11'h0A0}) else $error("slow threshold");
  a_thr_fast: assert property (o_rate_100 |-> !o_port_serial
    && o_tx_threshold inside {11'h080, 11'h100, 11'h200, 11'h400})
    else $error("fast threshold");
  a_mii_loop: assert property (i_tx_en && !o_port_serial && !o_pcs_en
    |=> o_mii_txen == !$past(o_loop_internal)) else $error("mii enable");
  a_sym_tx: assert property (i_tx_en && o_pcs_en |=> o_sym_txen)
    else $error("symbol enable");
  a_accept_match: assert property (o_addr_match |-> o_frame_accept)
    else $error("match not accepted");
  a_hash_all: assert property (o_filt_mode == FILT_HASHALL
    |-> o_mcast_hash && o_phys_hash) else $error("hash flags");
  a_ro_keep: assert property (wr_mode && !i_setup_load
    |=> $stable(o_mcast_hash) && $stable(o_phys_hash)) else $error("ro bits");
  c_start: cover property (o_desc_req ##1 o_rx_running);
  c_suspend: cover property ($rose(o_rx_suspended));
  c_loop_tx: cover property (i_tx_en && o_loop_internal);
endmodule : omc_asserts

bind omc_mode_ctl omc_asserts u_asserts (.*);

// File: bench/omc_far_model.sv
// Far side model: receive link source and descriptor engine
`timescale 1ns/100ps
module omc_far_model (
  // Device clock
  input  wire logic i_clk,
  // Descriptor engine
  input  wire logic i_desc_req,
  output logic      o_desc_done,
  output logic      o_desc_owned,
  // Receive link
  output logic      o_rx_clk,
  output logic      o_rx_dv
);
  int   dly = 0;
  logic own = 1'b1;
  initial begin
    o_desc_done = 1'b0;
    o_desc_owned = 1'b0;
    o_rx_clk = 1'b0;
    o_rx_dv = 1'b0;
  end
  // Owned flag carries the inverse outside the answer cycle
  always @(posedge i_clk) begin
    if (i_desc_req === 1'b1) begin
      repeat (dly) @(posedge i_clk);
      o_desc_done <= 1'b1;
      o_desc_owned <= own;
      @(posedge i_clk);
      o_desc_done <= 1'b0;
      o_desc_owned <= !own;
    end
  end
  // Link clock runs only around a frame, unrelated to the device clock
  task frame(input int n);
    #37;
    repeat (n) begin
      o_rx_dv = 1'b1;
      #100 o_rx_clk = 1'b1;
      #100 o_rx_clk = 1'b0;
    end
    o_rx_dv = 1'b0;
    repeat (3) begin
      #100 o_rx_clk = 1'b1;
      #100 o_rx_clk = 1'b0;
    end
  endtask : frame
endmodule : omc_far_model

// File: src/omc_cfg_decode.sv
// Decoder of threshold, port, loopback and filter fields
`timescale 1ns/100ps
`include "omc_map.svh"
module omc_cfg_decode (
  // Configuration carrier
  omc_cfg_if.dec cfg
);
  import omc_pkg::*;

  function automatic omc_filt_type filt_dec(input logic [4:0] b);
    omc_filt_type f;
    f = FILT_RSVD;
    casez (b)
      5'b00000: f = FILT_PERF16;
      5'b00001: f = FILT_HASH1;   // R16
      5'b00011: f = FILT_HASHALL; // R17
      5'b00100: f = FILT_INVERSE;
      5'b?100?: f = FILT_PROMISC;
      5'b01011: f = FILT_PROMISC;
      5'b1000?: f = FILT_ALLMC;
      5'b10011: f = FILT_ALLMC;
      default:  f = FILT_RSVD;
    endcase
    return f; // R15
  endfunction : filt_dec

  logic [1:0] thr;
  assign thr = cfg.mode[`OMC_B_THR_HI:`OMC_B_THR_LO];

  always_comb begin
    cfg.port_serial = ~cfg.mode[`OMC_B_PORT]; // R10
    cfg.rate_100    = cfg.mode[`OMC_B_PORT] & ~cfg.mode[`OMC_B_RATE10];
    cfg.pcs_en      = cfg.rate_100 & cfg.mode[`OMC_B_PCS]; // R10 R12
    cfg.scr_en      = cfg.pcs_en & cfg.mode[`OMC_B_SCR]; // R10 R12
    cfg.store_fwd   = cfg.mode[`OMC_B_SF]; // R9
    case (thr)
      2'b00:   cfg.thr_bytes = cfg.rate_100 ? `OMC_THR_F0 : `OMC_THR_S0;
      2'b01:   cfg.thr_bytes = cfg.rate_100 ? `OMC_THR_F1 : `OMC_THR_S1;
      2'b10:   cfg.thr_bytes = cfg.rate_100 ? `OMC_THR_F2 : `OMC_THR_S2;
      default: cfg.thr_bytes = cfg.rate_100 ? `OMC_THR_F3 : `OMC_THR_S3;
    endcase // R9
    cfg.loop = omc_loop_type'(
      cfg.mode[`OMC_B_LOOP_HI:`OMC_B_LOOP_LO]); // R11
    cfg.filt = filt_dec({cfg.mode[`OMC_B_PM], cfg.mode[`OMC_B_PR],
                         cfg.mode[`OMC_B_IF], cfg.mode[`OMC_B_HO],
                         cfg.mode[`OMC_B_HP]});
    cfg.mcast_hash = cfg.mode[`OMC_B_HP]; // R7 R8
    cfg.phys_hash  = cfg.mode[`OMC_B_HP] & cfg.mode[`OMC_B_HO]; // R1 R8
  end
endmodule : omc_cfg_decode

// File: src/omc_cfg_if.sv
// Carrier between the register core and the configuration decoder
`timescale 1ns/100ps
interface omc_cfg_if;
  import omc_pkg::*;
  logic [31:0]  mode;
  logic [10:0]  thr_bytes;
  logic         store_fwd;
  logic         port_serial;
  logic         rate_100;
  logic         pcs_en;
  logic         scr_en;
  omc_loop_type loop;
  omc_filt_type filt;
  logic         mcast_hash;
  logic         phys_hash;
  modport dec (input mode, output thr_bytes, store_fwd, port_serial,
               rate_100, pcs_en, scr_en, loop, filt, mcast_hash,
               phys_hash);
  modport core (output mode, input thr_bytes, store_fwd, port_serial,
                rate_100, pcs_en, scr_en, loop, filt, mcast_hash,
                phys_hash);
endinterface : omc_cfg_if

// File: src/omc_map.svh
// Register map, field positions and constants of the operating mode block
// Operation
// [R1] Hash-only indicator set: hash-filter both physical and multicast addresses.
// [R2] Start places receive in running, fetching from the current list position.
// [R3] No owned descriptor: suspend receive and set buffer unavailable status.
// [R4] Start honoured only while stopped; software sets list base first.
// [R5] Clear stops after current frame; next position kept for restart.
// [R6] Stop acts only while receive is running or suspended.
// [R7] Hash/perfect indicator clear: perfect filtering against setup address list.
// [R8] Indicator set: multicast hashed; physical hashed only with hash-only set.
// [R9] Threshold field picks 72..160 or 128..1024 bytes; bit 21 store-and-forward.
// [R10] Bits 18,22,23,24 select serial or MII port, rate, coding, scrambling.
// [R11] Loopback field: 00 normal, 01 internal, 10 external.
// [R12] Internal loopback on both ports also exercises coding and scrambler; pcs_en and scr_en come on only for the symbol port, never the serial port.
// [R13] Internal loopback on symbol port still sends symbols to network.
// [R14] Internal loopback on MII port holds MII transmit enable low.
// [R15] Filter bits decode perfect, inverse, promiscuous, pass-all-multicast.
// [R16] Only bit 0 set: 512-bit multicast hash plus one perfect address.
// [R17] Bits 2 and 0 set: 512-bit hash for multicast and physical.
// [R18] Receive-all accepts frames, still reports filter result as match.
// [R19] Software changes configuration fields only while processes stopped.
// [R20] Reset brings promiscuous receive mode on.
// [R21] Writes to read-only filter indicator bits are ignored.
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH
`define OMC_OFF_MODE    12'h000
`define OMC_OFF_STATUS  12'h004
`define OMC_OFF_RLB     12'h008
`define OMC_OFF_CURPOS  12'h00C
`define OMC_OFF_DECODE  12'h010
`define OMC_MODE_RST    32'h3200_0040
`define OMC_RO_MASK     32'h0000_0015
`define OMC_B_HP        0
`define OMC_B_RUN       1
`define OMC_B_HO        2
`define OMC_B_IF        4
`define OMC_B_PR        6
`define OMC_B_PM        7
`define OMC_B_LOOP_LO   10
`define OMC_B_LOOP_HI   11
`define OMC_B_THR_LO    14
`define OMC_B_THR_HI    15
`define OMC_B_PORT      18
`define OMC_B_SF        21
`define OMC_B_RATE10    22
`define OMC_B_PCS       23
`define OMC_B_SCR       24
`define OMC_B_RXALL     30
`define OMC_ST_RBU      7
`define OMC_ST_STATE_LO 8
`define OMC_ST_STATE_HI 9
`define OMC_ST_STOPP    10
`define OMC_ST_FRAME    11
`define OMC_DESC_STRIDE 32'h0000_0010
`define OMC_THR_S0      11'h048
`define OMC_THR_S1      11'h060
`define OMC_THR_S2      11'h080
`define OMC_THR_S3      11'h0A0
`define OMC_THR_F0      11'h080
`define OMC_THR_F1      11'h100
`define OMC_THR_F2      11'h200
`define OMC_THR_F3      11'h400
`endif

// File: src/omc_mode_ctl.sv
// Operating mode register, receive process control and APB slave
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "omc_map.svh"
module omc_mode_ctl (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Setup-frame engine: loads the read-only filter indicators
  input  wire logic        i_setup_load,
  input  wire logic        i_setup_hp,
  input  wire logic        i_setup_ho,
  input  wire logic        i_setup_inv,
  // Receive descriptor engine
  output logic             o_desc_req,
  output logic      [31:0] o_desc_addr,
  input  wire logic        i_desc_done,
  input  wire logic        i_desc_owned,
  // Receive link pins
  input  wire logic        i_rx_clk,
  input  wire logic        i_rx_dv,
  // Destination address checks of the current frame
  input  wire logic        i_da_mcast,
  input  wire logic        i_da_perfect,
  input  wire logic        i_da_hash,
  output logic             o_addr_match,
  output logic             o_frame_accept,
  output logic             o_mcast_hash,
  output logic             o_phys_hash,
  output omc_pkg::omc_filt_type o_filt_mode,
  // Transmit path and port control
  input  wire logic        i_tx_en,
  output logic             o_mii_txen,
  output logic             o_sym_txen,
  output logic             o_loop_internal,
  output logic             o_loop_external,
  output logic             o_port_serial,
  output logic             o_rate_100,
  output logic             o_pcs_en,
  output logic             o_scr_en,
  output logic      [10:0] o_tx_threshold,
  output logic             o_store_fwd,
  // Receive process state
  output logic             o_rx_running,
  output logic             o_rx_suspended
);
  import omc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_hit(input logic [11:0] a);
    return (a == `OMC_OFF_MODE)   || (a == `OMC_OFF_STATUS) ||
           (a == `OMC_OFF_RLB)    || (a == `OMC_OFF_CURPOS) ||
           (a == `OMC_OFF_DECODE);
  endfunction : addr_hit

  // Address check result for one frame under a given filter mode
  function automatic logic filt_match(input omc_filt_type f,
                                      input logic mc,
                                      input logic perf,
                                      input logic hsh,
                                      input logic phys_hash);
    logic m;
    m = 1'b0;
    case (f)
      FILT_PERF16:  m = perf; // R7
      FILT_HASH1:   m = mc ? hsh : perf; // R8 R16
      FILT_HASHALL: m = hsh; // R1 R17
      FILT_INVERSE: m = ~perf;
      FILT_PROMISC: m = 1'b1;
      FILT_ALLMC:   m = mc | (phys_hash ? hsh : perf);
      default:      m = perf;
    endcase
    return m;
  endfunction : filt_match

  ////////////////////////////////////////////////////////////////////////
  // Configuration decoder

  omc_cfg_if cfg ();

  omc_cfg_decode u_dec (
    .cfg (cfg)
  );

  omc_state_type q;
  omc_state_type d;

  assign cfg.mode = q.mode;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        setup_ph;
  logic        access_ph;
  logic        hit;
  logic        wr_mode;
  logic        wr_status;
  logic        wr_rlb;
  logic [31:0] decode_word;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign setup_ph  = i_psel & ~i_penable;
  assign access_ph = i_psel & i_penable;
  assign hit       = addr_hit(i_paddr);
  assign wr_mode   = access_ph & i_pwrite & (i_paddr == `OMC_OFF_MODE);
  assign wr_status = access_ph & i_pwrite & (i_paddr == `OMC_OFF_STATUS);
  assign wr_rlb    = access_ph & i_pwrite & (i_paddr == `OMC_OFF_RLB);

  always_comb begin
    decode_word        = '0;
    decode_word[10:0]  = cfg.thr_bytes;
    decode_word[11]    = cfg.store_fwd;
    decode_word[12]    = cfg.port_serial;
    decode_word[13]    = cfg.rate_100;
    decode_word[14]    = cfg.pcs_en;
    decode_word[15]    = cfg.scr_en;
    decode_word[17:16] = cfg.loop;
    decode_word[20:18] = cfg.filt;
    decode_word[21]    = cfg.mcast_hash;
    decode_word[22]    = cfg.phys_hash;
  end

  always_comb begin
    status_word = '0;
    status_word[`OMC_ST_RBU] = q.rbu;
    status_word[`OMC_ST_STATE_HI:`OMC_ST_STATE_LO] = q.rx;
    status_word[`OMC_ST_STOPP] = ~q.mode[`OMC_B_RUN] &
                                 (q.rx != RX_STOPPED);
    status_word[`OMC_ST_FRAME] = q.frame;
  end

  always_comb begin
    case (i_paddr)
      `OMC_OFF_MODE:   rd_mux = q.mode;
      `OMC_OFF_STATUS: rd_mux = status_word;
      `OMC_OFF_RLB:    rd_mux = q.rlb;
      `OMC_OFF_CURPOS: rd_mux = q.cur;
      `OMC_OFF_DECODE: rd_mux = decode_word;
      default:         rd_mux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Link edge detection

  logic clk_rise;
  logic frame_start;
  logic frame_end;
  logic run;
  logic rbu_set;
  logic rbu_clr;
  logic mii_loop;

  assign clk_rise    = q.sync2[1] & ~q.clk_last;
  assign frame_start = clk_rise & ~q.frame & q.sync2[0];
  assign frame_end   = clk_rise & q.frame & ~q.sync2[0];
  assign run         = q.mode[`OMC_B_RUN];
  assign rbu_clr     = wr_status & i_pwdata[`OMC_ST_RBU];
  assign mii_loop    = (cfg.loop == LOOP_INT) & ~cfg.port_serial &
                       ~cfg.pcs_en;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d          = q;
    d.desc_req = 1'b0;
    rbu_set    = 1'b0;
    d.sync1    = {i_rx_clk, i_rx_dv};
    d.sync2    = q.sync1;
    d.clk_last = q.sync2[1];
    if (clk_rise) begin
      d.frame = q.sync2[0];
    end
    if (setup_ph) begin
      d.prdata = rd_mux;
    end
    // Indicator bits keep their value across software writes
    if (wr_mode) begin
      d.mode = (i_pwdata & ~`OMC_RO_MASK) |
               (q.mode & `OMC_RO_MASK); // R21
    end
    if (i_setup_load) begin
      d.mode[`OMC_B_HP] = i_setup_hp;
      d.mode[`OMC_B_HO] = i_setup_ho;
      d.mode[`OMC_B_IF] = i_setup_inv;
    end
    if (wr_rlb) begin
      d.rlb = i_pwdata;
      if (q.rx == RX_STOPPED) begin
        d.cur = i_pwdata;
      end
    end
    case (q.rx)
      RX_STOPPED: begin
        if (run) begin
          d.rx       = RX_FETCH; // R2 R4
          d.desc_req = 1'b1;
        end
      end
      RX_FETCH: begin
        if (i_desc_done) begin
          if (i_desc_owned) begin
            d.rx = RX_RUNNING;
          end else begin
            d.rx    = RX_SUSPENDED; // R3
            rbu_set = 1'b1; // R3
          end
        end
      end
      RX_RUNNING: begin
        if (frame_end) begin
          d.cur = q.cur + `OMC_DESC_STRIDE; // R5
          if (run) begin
            d.rx       = RX_FETCH;
            d.desc_req = 1'b1;
          end else begin
            d.rx = RX_STOPPED; // R5 R6
          end
        end else if (!run && !q.frame) begin
          d.rx = RX_STOPPED; // R6
        end
      end
      RX_SUSPENDED: begin
        if (!run) begin
          d.rx = RX_STOPPED; // R6
        end else if (frame_start) begin
          d.rx       = RX_FETCH;
          d.desc_req = 1'b1;
        end
      end
      default: begin
        d.rx = RX_STOPPED;
      end
    endcase
    // A new shortage beats a clear in the same cycle
    d.rbu = (q.rbu & ~rbu_clr) | rbu_set;
    d.match = filt_match(cfg.filt, i_da_mcast, i_da_perfect, i_da_hash,
                         cfg.phys_hash);
    d.accept = d.match | q.mode[`OMC_B_RXALL]; // R18
    d.mii_txen = i_tx_en & ~mii_loop; // R14
    d.sym_txen = i_tx_en & cfg.pcs_en; // R13
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q.mode     <= `OMC_MODE_RST; // R20
      q.rlb      <= '0;
      q.cur      <= '0;
      q.prdata   <= '0;
      q.rx       <= RX_STOPPED;
      q.rbu      <= 1'b0;
      q.desc_req <= 1'b0;
      q.frame    <= 1'b0;
      q.sync1    <= '0;
      q.sync2    <= '0;
      q.clk_last <= 1'b0;
      q.match    <= 1'b0;
      q.accept   <= 1'b0;
      q.mii_txen <= 1'b0;
      q.sym_txen <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_prdata        = q.prdata;
  assign o_pready        = 1'b1;
  assign o_pslverr       = access_ph & ~hit;
  assign o_desc_req      = q.desc_req;
  assign o_desc_addr     = q.cur;
  assign o_addr_match    = q.match;
  assign o_frame_accept  = q.accept;
  assign o_mcast_hash    = cfg.mcast_hash;
  assign o_phys_hash     = cfg.phys_hash;
  assign o_filt_mode     = cfg.filt;
  assign o_mii_txen      = q.mii_txen;
  assign o_sym_txen      = q.sym_txen;
  assign o_loop_internal = (cfg.loop == LOOP_INT); // R11 R12
  assign o_loop_external = (cfg.loop == LOOP_EXT); // R11
  assign o_port_serial   = cfg.port_serial;
  assign o_rate_100      = cfg.rate_100;
  assign o_pcs_en        = cfg.pcs_en;
  assign o_scr_en        = cfg.scr_en;
  assign o_tx_threshold  = cfg.thr_bytes;
  assign o_store_fwd     = cfg.store_fwd;
  assign o_rx_running    = (q.rx == RX_RUNNING) || (q.rx == RX_FETCH);
  assign o_rx_suspended  = (q.rx == RX_SUSPENDED);
endmodule : omc_mode_ctl

// File: src/omc_pkg.sv
// Types shared by the operating mode block
package omc_pkg;
  typedef enum logic [1:0] {
    RX_STOPPED   = 2'b00,
    RX_FETCH     = 2'b01,
    RX_RUNNING   = 2'b10,
    RX_SUSPENDED = 2'b11
  } omc_rx_type;
  typedef enum logic [1:0] {
    LOOP_NORMAL = 2'b00,
    LOOP_INT    = 2'b01,
    LOOP_EXT    = 2'b10,
    LOOP_RSVD   = 2'b11
  } omc_loop_type;
  typedef enum logic [2:0] {
    FILT_PERF16  = 3'b000,
    FILT_HASH1   = 3'b001,
    FILT_HASHALL = 3'b010,
    FILT_INVERSE = 3'b011,
    FILT_PROMISC = 3'b100,
    FILT_ALLMC   = 3'b101,
    FILT_RSVD    = 3'b110
  } omc_filt_type;
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] rlb;
    logic [31:0] cur;
    logic [31:0] prdata;
    omc_rx_type  rx;
    logic        rbu;
    logic        desc_req;
    logic        frame;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic        clk_last;
    logic        match;
    logic        accept;
    logic        mii_txen;
    logic        sym_txen;
  } omc_state_type;
endpackage : omc_pkg
